// ==== bench/line_front_end.sv ====
// stand-in for the analog front end: tone meter and comparator source
// same clock as the core; bit period given as parameter
`timescale 1ns/1ps
module line_front_end #(
	parameter int BIT = 400
) (
	input wire logic i_clk,
	input wire logic i_tone,
	input wire logic i_tx_enable,
	output logic o_rx_bit
);
	int q[$];
	int pos = 0;
	int since = 0;
	int len = 0;
	logic pt = 1'b0;
	initial o_rx_bit = 1'b0;
	// half period between toggles, taken late in a bit so it is pure
	always @(posedge i_clk) begin
		pt <= i_tone;
		since <= (i_tone != pt) ? 1 : since + 1;
		if (i_tone != pt) len <= since;
		pos <= i_tx_enable ? pos + 1 : 0;
		if (i_tx_enable && pos % BIT == BIT * 3 / 4) q.push_back(len);
	end
	// comparator output, msb first, one bit per baud period
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			o_rx_bit <= b[i];
			repeat (BIT) @(posedge i_clk);
		end
	endtask : send
endmodule : line_front_end

// ==== bench/modem_asserts.sv ====
// port assertions for the powerline modem core
// bound onto every powerline_modem, one clock domain
`timescale 1ns/1ps
module modem_asserts #(
	parameter logic [13:0] BIT_CYC = 14'h0040
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_tx_valid,
	input wire logic i_tx_last,
	input wire logic o_tx_ready,
	input wire logic [7:0] i_threshold,
	input wire logic [7:0] i_level,
	input wire logic o_rx_valid,
	input wire logic o_tone,
	input wire logic o_tx_enable,
	input wire logic o_band_occupied,
	input wire logic o_tx_done,
	input wire logic o_access_fail
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	logic [31:0] on_cyc;
	// length of the current burst, read when done pulses
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) on_cyc <= '0;
		else on_cyc <= o_tx_enable ? on_cyc + 1 : '0;
	end
	sequence s_last;
		i_tx_valid && i_tx_last && o_tx_ready;
	endsequence
	sequence s_two_on;
		o_tx_enable ##1 o_tx_enable;
	endsequence
	a_ready_drop: assert property (s_last |=> !o_tx_ready)
		else $error("ready held after last byte");
	a_tone_hold: assert property (o_tx_enable && $changed(o_tone) |=>
		(!o_tx_enable || $stable(o_tone)) [*8])
		else $error("tone half period too short");
	a_quiet_start: assert property ($rose(o_tx_enable) |-> $past(!o_band_occupied))
		else $error("send started on busy band");
	a_frame_len: assert property (o_tx_done |-> on_cyc % (8 * BIT_CYC) == 0 &&
		on_cyc >= 24 * BIT_CYC)
		else $error("burst not whole bytes");
	a_done_end: assert property ($fell(o_tx_enable) |-> o_tx_done)
		else $error("burst ended without done");
	a_pulse_one: assert property (o_tx_done || o_access_fail |=> !o_tx_done && !o_access_fail)
		else $error("pulse longer than one cycle");
	a_fail_idle: assert property (o_access_fail |-> o_tx_ready && !o_tx_enable)
		else $error("fail while sending");
	a_half_dup: assert property (s_two_on |-> !$rose(o_rx_valid))
		else $error("byte received while sending");
	a_busy_held: assert property ($rose(o_band_occupied) |->
		$past(i_level > i_threshold, 10) && $past(i_level > i_threshold, 30))
		else $error("busy without lasting level");
	a_busy_drop: assert property ((i_level <= i_threshold) [*8] |=> !o_band_occupied)
		else $error("busy held after level fell");
endmodule : modem_asserts

bind powerline_modem modem_asserts #(.BIT_CYC(BIT_CYC)) u_modem_asserts (.i_clk, .i_nrst,
	.i_tx_valid, .i_tx_last, .o_tx_ready, .i_threshold, .i_level, .o_rx_valid, .o_tone,
	.o_tx_enable, .o_band_occupied, .o_tx_done, .o_access_fail);

// ==== bench/powerline_fsk_csma_transmit_test.sv ====
// self-checking bench for the powerline modem core
// drives the network side; the front end model plays the line
`timescale 1ns/1ps
module powerline_fsk_csma_transmit_test;
	localparam int LMIN = 850;
	localparam int LSTEP = 50;
	typedef struct {logic [15:0] d; int n; logic w; logic [7:0] c;} row_type;
	row_type rows[3] = '{'{16'h0000, 1, 1'b0, 8'h00}, '{16'hFF00, 1, 1'b1, 8'hF3},
		'{16'hA572, 2, 1'b0, 8'h00}};
	logic i_clk = 1'b0;
	logic i_nrst, i_tx_valid, i_tx_last, i_tx_retry, i_wide_dev, i_rx_ready, i_rx_resync;
	logic [7:0] i_tx_data, i_threshold, i_level;
	logic o_tx_ready, o_rx_valid, o_rx_crc_ok, o_rx_overrun, o_tone, o_tx_enable;
	logic o_band_occupied, o_tx_done, o_access_fail, i_rx_bit;
	logic [7:0] o_rx_data;
	int n_fail = 0, n_checks = 0, cyc = 0, t;
	powerline_modem #(.BIT_CYC(14'h0190), .LISTEN_MIN_CYC(22'h0352), .LISTEN_STEP_CYC(22'h0032),
		.DETECT_CYC(17'h0028), .TIMEOUT_CYC(27'h1388)) u_powerline_modem (.i_clk, .i_nrst,
		.i_tx_data, .i_tx_valid, .i_tx_last, .o_tx_ready, .i_tx_retry, .i_wide_dev,
		.i_threshold, .i_level, .i_rx_bit, .i_rx_ready, .i_rx_resync, .o_rx_data, .o_rx_valid,
		.o_rx_crc_ok, .o_rx_overrun, .o_tone, .o_tx_enable, .o_band_occupied, .o_tx_done,
		.o_access_fail);
	line_front_end #(.BIT(400)) u_line_front_end (.i_clk, .i_tone(o_tone),
		.i_tx_enable(o_tx_enable), .o_rx_bit(i_rx_bit));
	// 25 MHz clock and a cycle count
	always #20 i_clk = ~i_clk;
	always @(posedge i_clk) cyc <= cyc + 1;
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	task automatic put(input logic [7:0] d, input logic l);
		i_tx_data <= d;
		i_tx_valid <= 1'b1;
		i_tx_last <= l;
		@(posedge i_clk);
	endtask : put
	// one packet (or a resend), then the tone per bit against the bits
	task automatic frame(input logic [15:0] d, input int n, input logic w, input logic [7:0] c,
		input logic r);
		logic [31:0] bits;
		bits = (n == 2) ? {8'hAB, d, c} : {8'hAB, d[15:8], c, 8'h00};
		u_line_front_end.q.delete();
		i_wide_dev <= w;
		if (r) begin
			i_tx_retry <= 1'b1;
			@(posedge i_clk);
			i_tx_retry <= 1'b0;
		end else begin
			put(d[15:8], n == 1);
			if (n == 2) put(d[7:0], 1'b1);
			i_tx_valid <= 1'b0;
		end
		t = cyc;
		for (int k = 0; k < 2000 && !o_tx_enable; k++) @(posedge i_clk);
		// enable shows two edges after the wait reaches zero
		t = cyc - t - 2 - LMIN;
		check("listen", 1, t % LSTEP == 0 && t >= 0 && t <= 6 * LSTEP);
		for (int k = 0; k < 20000 && !o_tx_done; k++) @(posedge i_clk);
		check("done", 2'b11, {o_tx_done, o_tx_ready});
		for (int k = 0; k < (n + 2) * 8; k++)
			check("half", bits[31-k] ? (w ? 95 : 94) : 93, u_line_front_end.q[k]);
		check("bits", (n + 2) * 8, u_line_front_end.q.size());
	endtask : frame
	initial begin
		i_nrst <= 1'b0;
		i_tx_valid <= 1'b0;
		i_tx_last <= 1'b0;
		i_tx_retry <= 1'b0;
		i_wide_dev <= 1'b0;
		i_rx_ready <= 1'b0;
		i_rx_resync <= 1'b0;
		i_tx_data <= 8'h00;
		i_threshold <= 8'h40;
		i_level <= 8'h00;
		repeat (15) @(posedge i_clk);
		check("reset", 7'h40, {o_tx_ready, o_tx_enable, o_tone, o_rx_valid, o_band_occupied,
			o_tx_done, o_access_fail});
		@(posedge i_clk);
		i_nrst <= 1'b1;
		@(posedge i_clk);
		foreach (rows[i]) begin
			frame(rows[i].d, rows[i].n, rows[i].w, rows[i].c, 1'b0);
			$display("packet row %0d done", i);
		end
		// band detect: equal level, short burst, then held busy
		i_level <= i_threshold;
		repeat (60) @(posedge i_clk);
		i_level <= 8'h41;
		repeat (30) @(posedge i_clk);
		check("short", 0, o_band_occupied);
		i_level <= 8'hFF;
		repeat (60) @(posedge i_clk);
		check("busy", 1, o_band_occupied);
		// raising the threshold to the level releases the band at once
		i_threshold <= 8'hFF;
		repeat (2) @(posedge i_clk);
		check("threshold", 0, o_band_occupied);
		i_threshold <= 8'h40;
		repeat (60) @(posedge i_clk);
		check("busy again", 1, o_band_occupied);
		u_line_front_end.q.delete();
		put(8'h3C, 1'b1);
		i_tx_valid <= 1'b0;
		t = cyc;
		for (int k = 0; k < 6000 && !o_access_fail; k++) @(posedge i_clk);
		check("timeout", 1, cyc - t >= 4998 && cyc - t <= 5004 && o_tx_ready);
		check("no send", 0, u_line_front_end.q.size());
		i_level <= 8'h00;
		repeat (10) @(posedge i_clk);
		frame(16'h3C00, 1, 1'b0, 8'hB4, 1'b1);
		$display("access and resend done");
		// receive: crc, overrun with a stalled reader, resync, drain
		u_line_front_end.send(8'hAB);
		u_line_front_end.send(8'hA5);
		check("crc bad", 2'b10, {o_rx_valid, o_rx_crc_ok});
		u_line_front_end.send(8'h72);
		check("crc ok", 1, o_rx_crc_ok);
		u_line_front_end.send(8'h5A);
		check("overrun", 1, o_rx_overrun);
		i_rx_resync <= 1'b1;
		@(posedge i_clk);
		i_rx_resync <= 1'b0;
		repeat (2) @(posedge i_clk);
		check("cleared", 0, o_rx_overrun);
		check("rx a", 8'hA5, o_rx_data);
		i_rx_ready <= 1'b1;
		@(posedge i_clk);
		i_rx_ready <= 1'b0;
		@(posedge i_clk);
		check("rx b", 9'h172, {o_rx_valid, o_rx_data});
		i_rx_ready <= 1'b1;
		@(posedge i_clk);
		i_rx_ready <= 1'b0;
		@(posedge i_clk);
		check("empty", 0, o_rx_valid);
		$display("receive done");
		// half duplex: a synced receiver holds off the transmitter until resync
		u_line_front_end.send(8'hAB);
		put(8'h11, 1'b1);
		i_tx_valid <= 1'b0;
		repeat (1300) @(posedge i_clk);
		check("rx holds tx", 0, o_tx_enable);
		i_rx_resync <= 1'b1;
		@(posedge i_clk);
		i_rx_resync <= 1'b0;
		for (int k = 0; k < 1300 && !o_tx_enable; k++) @(posedge i_clk);
		check("tx after resync", 1, o_tx_enable);
		$display("half duplex done");
		summarize();
	end
	// watchdog well past the expected run length
	initial begin
		repeat (100000) @(posedge i_clk);
		n_fail++;
		summarize();
	end
endmodule : powerline_fsk_csma_transmit_test

// ==== verilog/packet_mem.sv ====
// byte store for one outgoing packet, kept for resending
// assumes write and read ports on the same clock; read data is registered
`timescale 1ns/1ps
module packet_mem #(
	parameter int DW = 8,
	parameter int AW = 6
) (
	input wire logic i_clk,
	input wire logic i_wr_en,
	input wire logic [AW-1:0] i_wr_addr,
	input wire logic [DW-1:0] i_wr_data,
	input wire logic [AW-1:0] i_rd_addr,
	output logic [DW-1:0] o_rd_data
);
	logic [DW-1:0] mem [2**AW];

	// no reset on the array: contents are only read after being written
	always_ff @(posedge i_clk) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_data;
		end
		o_rd_data <= mem[i_rd_addr];
	end
endmodule : packet_mem

// ==== verilog/powerline_modem.sv ====
// digital core of a half-duplex powerline fsk modem with carrier sense access
// assumes bytes from the network layer on i_clk, analog pins asynchronous
`timescale 1ns/1ps
module powerline_modem #(
	parameter logic [13:0] BIT_CYC = 14'(powerline_pkg::BIT_CYC),
	parameter logic [21:0] LISTEN_MIN_CYC = 22'(powerline_pkg::LISTEN_MIN_CYC),
	parameter logic [21:0] LISTEN_STEP_CYC = 22'(powerline_pkg::LISTEN_STEP_CYC),
	parameter logic [16:0] DETECT_CYC = 17'(powerline_pkg::DETECT_CYC),
	parameter logic [26:0] TIMEOUT_CYC = 27'(powerline_pkg::TIMEOUT_CYC)
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	input wire logic i_tx_last,
	output logic o_tx_ready,
	input wire logic i_tx_retry,
	input wire logic i_wide_dev,
	input wire logic [7:0] i_threshold,
	input wire logic [7:0] i_level,
	input wire logic i_rx_bit,
	input wire logic i_rx_ready,
	input wire logic i_rx_resync,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	output logic o_rx_crc_ok,
	output logic o_rx_overrun,
	output logic o_tone,
	output logic o_tx_enable,
	output logic o_band_occupied,
	output logic o_tx_done,
	output logic o_access_fail
);
	import powerline_pkg::*;

	typedef struct packed {
		tx_state_type tx_state;
		phase_type phase;
		logic tx_ready;
		logic [7:0] lfsr;
		logic [21:0] wait_cnt;
		logic [26:0] tout_cnt;
		logic [13:0] baud_cnt;
		logic [2:0] bit_idx;
		logic [7:0] shift;
		logic [5:0] byte_idx;
		logic [5:0] len;
		logic [7:0] crc_tx;
		logic tone;
		logic [7:0] tone_cnt;
		logic tx_en;
		logic done, fail;
		logic [7:0] lvl_s1, lvl_s2, lvl_s3, level;
		logic [16:0] busy_cnt;
		logic band_busy;
		logic rx_s1, rx_s2, rx_s3, rx_bit;
		logic [13:0] rx_cnt;
		logic [7:0] rx_shift;
		logic rx_sync;
		logic [2:0] rx_bits;
		logic [7:0] crc_rx;
		logic crc_ok;
		logic overrun;
		logic [7:0] buf0, buf1;
		logic [1:0] buf_cnt;
		logic rx_valid;
	} state_type;

	state_type st, next_st;
	logic [7:0] mem_rd;
	logic mem_wr;
	logic [5:0] mem_wr_addr;

	// packet bytes are written as accepted, read back by byte index
	packet_mem #(.DW(8), .AW(MEM_AW)) u_mem (
		.i_clk(i_clk),
		.i_wr_en(mem_wr),
		.i_wr_addr(mem_wr_addr),
		.i_wr_data(i_tx_data),
		.i_rd_addr(st.byte_idx),
		.o_rd_data(mem_rd)
	);

	// write strobe follows the accept handshake
	always_comb begin
		mem_wr = i_tx_valid & st.tx_ready;
		mem_wr_addr = (st.tx_state == T_IDLE) ? 6'h00 : st.byte_idx;
	end

	// next state for transmit, band detect and receive in one pass
	always_comb begin
		logic [2:0] pick;
		logic [21:0] rand_wait;
		logic busy, sample, push, pop;
		logic [7:0] half, rx_byte, crc_new;
		logic [1:0] cnt;
		pick = 3'h0;
		rand_wait = 22'h00_0000;
		busy = 1'b0;
		half = 8'h00;
		sample = 1'b0;
		rx_byte = 8'h00;
		push = 1'b0;
		pop = 1'b0;
		cnt = 2'h0;
		crc_new = 8'h00;
		next_st = st;
		next_st.done = 1'b0;
		next_st.fail = 1'b0;
		// free-running lfsr; index 7 folds onto 3 to keep seven values
		next_st.lfsr = {st.lfsr[6:0], st.lfsr[7] ^ st.lfsr[5] ^ st.lfsr[4] ^ st.lfsr[3]};
		pick = (st.lfsr[2:0] == 3'h7) ? 3'h3 : st.lfsr[2:0];
		rand_wait = LISTEN_MIN_CYC + 22'(pick) * LISTEN_STEP_CYC;
		// level pins: three flops, a change counts when stages two and three agree
		next_st.lvl_s1 = i_level;
		next_st.lvl_s2 = st.lvl_s1;
		next_st.lvl_s3 = st.lvl_s2;
		if (st.lvl_s2 == st.lvl_s3) begin
			next_st.level = st.lvl_s3;
		end
		// band detector must see the signal above threshold for the full time
		if (st.level > i_threshold) begin
			if (st.busy_cnt == DETECT_CYC - 17'h0_0001) begin
				next_st.band_busy = 1'b1;
			end else begin
				next_st.busy_cnt = st.busy_cnt + 17'h0_0001;
			end
		end else begin
			next_st.busy_cnt = 17'h0_0000;
			next_st.band_busy = 1'b0;
		end
		// a packet being received also holds off our own transmission
		busy = st.band_busy | st.rx_sync;
		// transmit sequencer
		case (st.tx_state)
			T_IDLE: begin
				if (mem_wr) begin
					next_st.byte_idx = 6'h01;
					next_st.tx_state = T_LOAD;
					if (i_tx_last) begin
						next_st.len = 6'h01;
						next_st.tx_ready = 1'b0;
						next_st.tx_state = T_LISTEN;
						next_st.wait_cnt = rand_wait;
						next_st.tout_cnt = TIMEOUT_CYC;
					end
				end else if (i_tx_retry && st.len != 6'h00) begin
					next_st.tx_ready = 1'b0;
					next_st.tx_state = T_LISTEN;
					next_st.wait_cnt = rand_wait;
					next_st.tout_cnt = TIMEOUT_CYC;
				end
			end
			T_LOAD: begin
				if (mem_wr) begin
					next_st.byte_idx = st.byte_idx + 6'h01;
					// oversized packets are cut at 63 bytes, one short of the memory depth
					if (i_tx_last || st.byte_idx == MEM_LAST - 6'h01) begin
						next_st.len = st.byte_idx + 6'h01;
						next_st.tx_ready = 1'b0;
						next_st.tx_state = T_LISTEN;
						next_st.wait_cnt = rand_wait;
						next_st.tout_cnt = TIMEOUT_CYC;
					end
				end
			end
			T_LISTEN: begin
				if (st.tout_cnt == 27'h000_0000) begin
					next_st.fail = 1'b1;
					next_st.tx_ready = 1'b1;
					next_st.tx_state = T_IDLE;
				end else begin
					next_st.tout_cnt = st.tout_cnt - 27'h000_0001;
					if (busy) begin
						next_st.wait_cnt = rand_wait;
					end else if (st.wait_cnt == 22'h00_0000) begin
						// quiet for the whole period: start with the preamble
						next_st.tx_state = T_SEND;
						next_st.tx_en = 1'b1;
						next_st.phase = P_PRE;
						next_st.shift = PREAMBLE;
						next_st.bit_idx = 3'h0;
						next_st.baud_cnt = 14'h0000;
						next_st.byte_idx = 6'h00;
						next_st.crc_tx = CRC_INIT;
						next_st.tone = 1'b0;
						next_st.tone_cnt = 8'h00;
					end else begin
						next_st.wait_cnt = st.wait_cnt - 22'h00_0001;
					end
				end
			end
			T_SEND: begin
				// tone divider picked from the bit on air and the unregistered i_wide_dev input
				half = !st.shift[7] ? HALF_ZERO : (i_wide_dev ? HALF_WIDE : HALF_ONE);
				if (st.tone_cnt >= half - 8'h01) begin
					next_st.tone_cnt = 8'h00;
					next_st.tone = ~st.tone;
				end else begin
					next_st.tone_cnt = st.tone_cnt + 8'h01;
				end
				if (st.baud_cnt == BIT_CYC - 14'h0001) begin
					next_st.baud_cnt = 14'h0000;
					next_st.bit_idx = st.bit_idx + 3'h1;
					next_st.shift = {st.shift[6:0], 1'b0};
					if (st.bit_idx == 3'h7) begin
						// byte boundary: memory output settled during the last byte
						if (st.phase == P_CRC) begin
							next_st.tx_state = T_IDLE;
							next_st.tx_en = 1'b0;
							next_st.tone = 1'b0;
							next_st.done = 1'b1;
							next_st.tx_ready = 1'b1;
						end else if (st.phase == P_DATA && st.byte_idx == st.len) begin
							next_st.phase = P_CRC;
							next_st.shift = st.crc_tx;
						end else begin
							next_st.phase = P_DATA;
							next_st.shift = mem_rd;
							next_st.crc_tx = crc8_next(st.crc_tx, mem_rd);
							next_st.byte_idx = st.byte_idx + 6'h01;
						end
					end
				end else begin
					next_st.baud_cnt = st.baud_cnt + 14'h0001;
				end
			end
			default: begin
				next_st.tx_state = T_IDLE;
			end
		endcase
		// receive pin synchroniser
		next_st.rx_s1 = i_rx_bit;
		next_st.rx_s2 = st.rx_s1;
		next_st.rx_s3 = st.rx_s2;
		if (st.rx_s2 == st.rx_s3) begin
			next_st.rx_bit = st.rx_s3;
		end
		// bit clock realigns on each edge, samples mid-bit
		if (next_st.rx_bit != st.rx_bit || st.rx_cnt == BIT_CYC - 14'h0001) begin
			next_st.rx_cnt = 14'h0000;
		end else begin
			next_st.rx_cnt = st.rx_cnt + 14'h0001;
		end
		sample = (st.rx_cnt == (BIT_CYC >> 1));
		rx_byte = {st.rx_shift[6:0], st.rx_bit};
		// receiver is deaf while transmitting
		if (st.tx_en || i_rx_resync) begin
			next_st.rx_sync = 1'b0;
			next_st.rx_shift = 8'h00;
		end else if (sample) begin
			next_st.rx_shift = rx_byte;
			if (!st.rx_sync) begin
				if (rx_byte == PREAMBLE) begin
					next_st.rx_sync = 1'b1;
					next_st.rx_bits = 3'h0;
					next_st.crc_rx = CRC_INIT;
					next_st.crc_ok = 1'b0;
				end
			end else begin
				next_st.rx_bits = st.rx_bits + 3'h1;
				if (st.rx_bits == 3'h7) begin
					push = 1'b1;
					crc_new = crc8_next(st.crc_rx, rx_byte);
					next_st.crc_rx = crc_new;
					next_st.crc_ok = (crc_new == 8'h00);
				end
			end
		end
		// two-entry buffer: pop first so a full buffer still takes a push
		pop = st.rx_valid & i_rx_ready;
		cnt = st.buf_cnt;
		if (pop) begin
			next_st.buf0 = st.buf1;
			cnt = cnt - 2'h1;
		end
		if (push) begin
			if (cnt == 2'h0) begin
				next_st.buf0 = rx_byte;
				cnt = 2'h1;
			end else if (cnt == 2'h1) begin
				next_st.buf1 = rx_byte;
				cnt = 2'h2;
			end else begin
				next_st.overrun = 1'b1;
			end
		end
		next_st.buf_cnt = cnt;
		next_st.rx_valid = (cnt != 2'h0);
		// overrun is sticky until the network layer resyncs
		if (i_rx_resync && !(push && cnt == 2'h2)) begin
			next_st.overrun = 1'b0;
		end
	end

	// all state in one register
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= '0;
			st.tx_ready <= 1'b1;
			st.lfsr <= LFSR_SEED;
		end else begin
			st <= next_st;
		end
	end

	// every output is a flop of the state record
	always_comb begin
		o_tx_ready = st.tx_ready;
		o_rx_data = st.buf0;
		o_rx_valid = st.rx_valid;
		o_rx_crc_ok = st.crc_ok;
		o_rx_overrun = st.overrun;
		o_tone = st.tone;
		o_tx_enable = st.tx_en;
		o_band_occupied = st.band_busy;
		o_tx_done = st.done;
		o_access_fail = st.fail;
	end
endmodule : powerline_modem

// ==== verilog/powerline_pkg.sv ====
// constants and helpers for the powerline fsk modem digital core
// assumes a single 25 MHz system clock feeding every process
package powerline_pkg;

	// system clock and line rate
	localparam int CLK_HZ = 25_000_000;
	localparam int BAUD = 2400;
	localparam int BIT_CYC = CLK_HZ / BAUD;

	// modulator tones in Hz and the half-period counts derived from them
	localparam int TONE_ZERO_HZ = 133_300;
	localparam int TONE_ONE_HZ = 131_800;
	localparam int TONE_WIDE_HZ = 130_400;
	localparam logic [7:0] HALF_ZERO = 8'(CLK_HZ / (2 * TONE_ZERO_HZ));
	localparam logic [7:0] HALF_ONE = 8'(CLK_HZ / (2 * TONE_ONE_HZ));
	localparam logic [7:0] HALF_WIDE = 8'(CLK_HZ / (2 * TONE_WIDE_HZ));

	// carrier sense timing in milliseconds, then in cycles
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int LISTEN_MIN_MS = 85;
	localparam int LISTEN_STEP_MS = 5;
	localparam int LISTEN_VALUES = 7;
	localparam int DETECT_MS = 4;
	localparam int TIMEOUT_MS = 3000;
	localparam int LISTEN_MIN_CYC = LISTEN_MIN_MS * CYC_PER_MS;
	localparam int LISTEN_STEP_CYC = LISTEN_STEP_MS * CYC_PER_MS;
	localparam int DETECT_CYC = DETECT_MS * CYC_PER_MS;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * CYC_PER_MS;

	// packet framing
	localparam logic [7:0] PREAMBLE = 8'hAB;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [7:0] LFSR_SEED = 8'h01;
	localparam int MEM_AW = 6;
	localparam logic [5:0] MEM_LAST = 6'h3F;

	// transmit sequencer
	typedef enum logic [1:0] {
		T_IDLE = 2'b00,
		T_LOAD = 2'b01,
		T_LISTEN = 2'b10,
		T_SEND = 2'b11
	} tx_state_type;

	// what the serializer is sending
	typedef enum logic [1:0] {
		P_PRE = 2'b00,
		P_DATA = 2'b01,
		P_CRC = 2'b10
	} phase_type;

	// msb-first crc-8 over one byte
	function automatic logic [7:0] crc8_next(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : crc8_next

endpackage : powerline_pkg
